//--- logic/stw_pkg.sv
/*
 * stw_pkg: constants and types of the single-wire thermostat slave port.
 * assumes a 125 MHz ref_clk; every cycle count is derived from that rate.
 */
`default_nettype none

package stw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and line timing
   localparam int CLK_MHZ       = 125;
   localparam int CLK_HZ        = CLK_MHZ * 1_000_000;
   localparam int RST_LOW_US    = 480;   // least low time taken as a reset
   localparam int PD_WAIT_US    = 30;    // wait before presence, inside 15..60
   localparam int PD_LOW_US     = 120;   // presence low time, inside 60..240
   localparam int WR_SAMPLE_US  = 30;    // write sample point, inside 15..60
   localparam int RD_HOLD_US    = 14;    // longest read data hold
   localparam int PDN_S         = 10;    // supply and line low before power down
   localparam int RST_LOW_CYC   = (RST_LOW_US * CLK_MHZ + 0) / 1;
   localparam int PD_WAIT_CYC   = PD_WAIT_US * CLK_MHZ;
   localparam int PD_LOW_CYC    = PD_LOW_US * CLK_MHZ;
   localparam int WR_SAMPLE_CYC = WR_SAMPLE_US * CLK_MHZ;
   localparam int RD_HOLD_CYC   = RD_HOLD_US * CLK_MHZ;   // exact product, no rounding
   localparam int PDN_CYC       = PDN_S * CLK_HZ;
   localparam int TMR_W         = 16;
   localparam int PDN_W         = 31;
   localparam logic [4:0] TOGGLE_PULSES = 5'h10;

   ////////////////////////////////////////////////////////////////////////////
   // command bytes
   localparam logic [7:0] CMD_CONV_START = 8'hEE;
   localparam logic [7:0] CMD_CONV_STOP  = 8'h22;
   localparam logic [7:0] CMD_RD_TEMP    = 8'hAA;
   localparam logic [7:0] CMD_WR_HIGH    = 8'h01;
   localparam logic [7:0] CMD_WR_LOW     = 8'h02;
   localparam logic [7:0] CMD_RD_HIGH    = 8'hA1;
   localparam logic [7:0] CMD_RD_LOW     = 8'hA2;
   localparam logic [7:0] CMD_WR_STATUS  = 8'h0C;
   localparam logic [7:0] CMD_RD_STATUS  = 8'hAC;

   ////////////////////////////////////////////////////////////////////////////
   // status register fields and reset values
   localparam int ST_DONE    = 7;
   localparam int ST_ONE     = 6;
   localparam int ST_NVB     = 5;
   localparam int ST_THF     = 4;
   localparam int ST_TLF     = 3;
   localparam int ST_TR      = 2;
   localparam int ST_POL     = 1;
   localparam int ST_ONESHOT = 0;
   localparam logic [7:0] HIGH_RST   = 8'h00;
   localparam logic [7:0] LOW_RST    = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h40;

   ////////////////////////////////////////////////////////////////////////////
   // write targets carried through the fifo
   typedef logic [1:0] stw_tgt_t;
   localparam stw_tgt_t TGT_HIGH   = 2'h0;
   localparam stw_tgt_t TGT_LOW    = 2'h1;
   localparam stw_tgt_t TGT_STATUS = 2'h2;
   localparam int FIFO_W = 10;
   localparam int FIFO_D = 4;

   typedef enum logic [2:0] {
      S_IDLE, S_RSTLOW, S_PDWAIT, S_PDLOW, S_CMD, S_WDATA, S_RDATA, S_PUSH
   } stw_state_e;

endpackage : stw_pkg

`default_nettype wire

//--- logic/stw_fifo.sv
/*
 * stw_fifo: small valid/ready fifo held in flip-flops.
 * assumes DEPTH is a power of two and both sides run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module stw_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } stw_fifo_s;

   stw_fifo_s q;
   stw_fifo_s d;
   logic      full;
   logic      empty;

   ////////////////////////////////////////////////////////////////////////////
   // flags and read port
   assign full      = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
   assign empty     = (q.wp == q.rp);
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (in_valid && !full) begin
         d.mem[q.wp[AW-1:0]] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : stw_fifo

`default_nettype wire

//--- logic/stw_slave.sv
/*
 * stw_slave: single-wire slave port of a programmable thermostat sensor.
 * assumes an external pull-up on the data line, a converter and comparator
 * outside that supply temp_value, conv_done, thf_set, tlf_set and
 * thermo_active, and a nonvolatile store that takes writes while nv_ready.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: after power-up, stored power-up mode bit 1 gives thermostat, 0 programming.
// RULE2: in thermostat mode line traffic is ignored; pin is only thermostat output.
// RULE3: master enters programming mode with supply low, 16 line pulses, supply back.
// RULE4: each supply-low 16-pulse sequence toggles mode; stored mode bit untouched.
// RULE5: supply and line low over 10 s powers down; restart uses stored mode bit.
// RULE6: EEh starts, 22h stops conversion, no data; AAh returns temperature byte.
// RULE7: 01h writes high trip limit, 02h low trip limit, one data byte each.
// RULE8: A1h returns high trip limit, A2h returns low trip limit.
// RULE9: 0Ch writes status register with a data byte; ACh returns it.
// RULE10: every transaction starts with master reset then device presence.
// RULE11: one master and this one slave; no multidrop addressing.
// RULE12: device only pulls the line low, never drives high; pull-up idles high.
// RULE13: high idle between bits is unlimited; low over 480 us resets.
// RULE14: master reset is at least 480 us low, then release and listen.
// RULE15: after reset rising edge wait 15-60 us, then presence low 60-240 us.
// RULE16: write slots start on master falling edge, last 60 us, 1 us recovery.
// RULE17: write slot sampled 15-60 us after fall; high is 1, low is 0.
// RULE18: master sends 1 by releasing within 15 us, 0 by holding low.
// RULE19: read slot: master low 1 us, device bit valid at most 14 us.
// RULE20: master read slots last at least 60 us with 1 us recovery.
// RULE21: master keeps initiation short and samples late in the 15 us window.
// RULE22: master starts every line signal except presence, which device originates.
// RULE23: write commands take exactly 8 data bits; read commands return 8 bits.
// RULE24: stop lets the running conversion finish, then idle until next start.
// RULE25: command and data bytes travel least significant bit first.
module stw_slave
   import stw_pkg::*;
#(
   parameter int RST_CYC    = RST_LOW_CYC,
   parameter int PDH_CYC    = PD_WAIT_CYC,
   parameter int PDL_CYC    = PD_LOW_CYC,
   parameter int SAMPLE_CYC = WR_SAMPLE_CYC,
   parameter int RDV_CYC    = RD_HOLD_CYC,
   parameter int PDN_LIMIT  = PDN_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       dq_in,
   output logic            dq_out,
   output logic            dq_oe_n,
   input  wire logic       vdd_in,
   input  wire logic [7:0] nv_high,
   input  wire logic [7:0] nv_low,
   input  wire logic [7:0] nv_status,
   input  wire logic [7:0] temp_value,
   input  wire logic       conv_done,
   input  wire logic       thf_set,
   input  wire logic       tlf_set,
   input  wire logic       thermo_active,
   input  wire logic       nv_ready,
   output logic            nv_wr,
   output logic      [1:0] nv_sel,
   output logic      [7:0] nv_data,
   output logic      [7:0] high_trip_limit,
   output logic      [7:0] low_trip_limit,
   output logic      [7:0] status_reg,
   output logic            conv_start,
   output logic            conv_stop,
   output logic            conv_run,
   output logic            thermo_mode
);

   typedef struct packed {
      logic             dq_m;
      logic             dq_s;
      logic             dq_p;
      logic             vdd_m;
      logic             vdd_s;
      logic             vdd_p;
      logic             loaded;
      logic             thermo;
      stw_state_e       state;
      logic             slot;
      logic [TMR_W-1:0] timer;
      logic [TMR_W-1:0] lowcnt;
      logic [2:0]       bitcnt;
      logic [7:0]       shift;
      stw_tgt_t         tgt;
      logic             drive;
      logic             oe_n;
      logic [4:0]       toggles;
      logic [PDN_W-1:0] pdn_cnt;
      logic             pdn;
      logic [7:0]       high;
      logic [7:0]       low;
      logic [7:0]       status;
      logic             run;
      logic             run_out;
      logic             start;
      logic             stop;
      logic             wr;
      stw_tgt_t         sel;
      logic [7:0]       wdata;
   } stw_slave_s;

   stw_slave_s          q;
   stw_slave_s          d;
   logic                fall;
   logic                rise;
   logic                f_in_ready;
   logic                f_out_valid;
   logic [FIFO_W-1:0]   f_out_data;
   logic [7:0]          rx_byte;

   ////////////////////////////////////////////////////////////////////////////
   // command decode helpers
   function automatic stw_tgt_t write_target(input logic [7:0] cmd);
      unique case (cmd)
         CMD_WR_HIGH: write_target = TGT_HIGH;
         CMD_WR_LOW:  write_target = TGT_LOW;
         default:     write_target = TGT_STATUS;
      endcase
   endfunction : write_target

   function automatic logic is_write(input logic [7:0] cmd);
      is_write = (cmd == CMD_WR_HIGH) || (cmd == CMD_WR_LOW) || (cmd == CMD_WR_STATUS);
   endfunction : is_write

   ////////////////////////////////////////////////////////////////////////////
   // write bytes queue toward the nonvolatile store
   stw_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_D)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .in_valid (q.state == S_PUSH),
      .in_ready (f_in_ready),
      .in_data  ({q.tgt, q.shift}),
      .out_valid(f_out_valid),
      .out_ready(nv_ready),
      .out_data (f_out_data)
   );

   assign fall    = q.dq_p & ~q.dq_s;
   assign rise    = ~q.dq_p & q.dq_s;
   assign rx_byte = {q.dq_s, q.shift[7:1]};  // lsb first, see RULE25

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d       = q;
      d.dq_m  = dq_in;
      d.dq_s  = q.dq_m;
      d.dq_p  = q.dq_s;
      d.vdd_m = vdd_in;
      d.vdd_s = q.vdd_m;
      d.vdd_p = q.vdd_s;
      d.start = 1'b0;
      d.stop  = 1'b0;
      d.wr    = 1'b0;

      // drain queued writes into the limit and status registers
      if (f_out_valid && nv_ready) begin
         d.wr    = 1'b1;
         d.sel   = f_out_data[9:8];
         d.wdata = f_out_data[7:0];
         unique case (f_out_data[9:8])
            TGT_HIGH: d.high = f_out_data[7:0];  // see RULE7
            TGT_LOW:  d.low  = f_out_data[7:0];  // see RULE7
            default: begin  // see RULE9
               d.status[ST_TR]      = f_out_data[ST_TR];
               d.status[ST_POL]     = f_out_data[ST_POL];
               d.status[ST_ONESHOT] = f_out_data[ST_ONESHOT];
               d.status[ST_THF]     = q.status[ST_THF] & f_out_data[ST_THF];
               d.status[ST_TLF]     = q.status[ST_TLF] & f_out_data[ST_TLF];
            end
         endcase
      end
      // set beats a clear in the same cycle
      if (thf_set) d.status[ST_THF] = 1'b1;
      if (tlf_set) d.status[ST_TLF] = 1'b1;
      d.status[ST_DONE] = conv_done;
      d.status[ST_ONE]  = 1'b1;
      d.status[ST_NVB]  = f_out_valid | ~nv_ready;

      d.lowcnt = q.dq_s ? '0 : ((&q.lowcnt) ? q.lowcnt : q.lowcnt + 1'b1);

      if (!q.vdd_s) begin
         // supply low: count mode toggle pulses, watch for power down
         d.state = S_IDLE;
         d.slot  = 1'b0;
         d.drive = 1'b0;
         if (fall && !(&q.toggles)) d.toggles = q.toggles + 1'b1;  // see RULE3
         if (q.dq_s) begin
            d.pdn_cnt = '0;
         end else if (q.pdn_cnt == PDN_W'(PDN_LIMIT - 1)) begin
            d.pdn = 1'b1;  // see RULE5
         end else begin
            d.pdn_cnt = q.pdn_cnt + 1'b1;
         end
      end else if (!q.vdd_p) begin
         // supply restored
         if (q.pdn) begin
            d.thermo = q.status[ST_TR];  // see RULE5
         end else if (q.toggles == TOGGLE_PULSES) begin
            d.thermo = ~q.thermo;  // see RULE4
         end
         d.toggles = '0;
         d.pdn     = 1'b0;
         d.pdn_cnt = '0;
      end else if (q.thermo) begin
         d.state = S_IDLE;  // see RULE2
         d.slot  = 1'b0;
         d.drive = 1'b0;
      end else if (!q.dq_s && !q.drive && q.lowcnt >= TMR_W'(RST_CYC)) begin
         d.state = S_RSTLOW;  // see RULE13
         d.slot  = 1'b0;
         d.drive = 1'b0;
      end else begin
         unique case (q.state)
            S_IDLE: begin
            end
            S_RSTLOW: begin
               if (rise) begin  // see RULE15
                  d.state = S_PDWAIT;
                  d.timer = '0;
               end
            end
            S_PDWAIT: begin
               d.timer = q.timer + 1'b1;
               if (q.timer == TMR_W'(PDH_CYC - 1)) begin
                  d.state = S_PDLOW;  // see RULE15
                  d.timer = '0;
                  d.drive = 1'b1;  // see RULE22
               end
            end
            S_PDLOW: begin
               d.timer = q.timer + 1'b1;
               if (q.timer == TMR_W'(PDL_CYC - 1)) begin
                  d.drive  = 1'b0;
                  d.state  = S_CMD;  // see RULE10, RULE11
                  d.bitcnt = '0;
                  d.slot   = 1'b0;
               end
            end
            S_CMD, S_WDATA: begin
               if (!q.slot) begin
                  if (fall) begin  // see RULE16
                     d.slot  = 1'b1;
                     d.timer = '0;
                  end
               end else begin
                  d.timer = q.timer + 1'b1;
                  if (q.timer == TMR_W'(SAMPLE_CYC - 1)) begin
                     d.slot   = 1'b0;
                     d.shift  = rx_byte;  // see RULE17
                     d.bitcnt = q.bitcnt + 1'b1;
                     if (q.bitcnt == 3'h7) begin
                        d.bitcnt = '0;
                        if (q.state == S_WDATA) begin
                           d.state = S_PUSH;  // see RULE23
                        end else if (is_write(rx_byte)) begin
                           d.state = S_WDATA;  // see RULE7
                           d.tgt   = write_target(rx_byte);
                        end else begin
                           d.state = S_RDATA;
                           unique case (rx_byte)
                              CMD_RD_TEMP:   d.shift = temp_value;  // see RULE6
                              CMD_RD_HIGH:   d.shift = q.high;      // see RULE8
                              CMD_RD_LOW:    d.shift = q.low;       // see RULE8
                              CMD_RD_STATUS: d.shift = q.status;    // see RULE9
                              default: begin
                                 d.state = S_IDLE;
                                 if (rx_byte == CMD_CONV_START) begin
                                    d.start = 1'b1;  // see RULE6
                                    d.run   = 1'b1;
                                 end
                                 if (rx_byte == CMD_CONV_STOP) begin
                                    d.stop = 1'b1;  // see RULE24
                                    d.run  = 1'b0;
                                 end
                              end
                           endcase
                        end
                     end
                  end
               end
            end
            S_RDATA: begin
               if (!q.slot) begin
                  if (fall) begin
                     d.slot  = 1'b1;
                     d.timer = '0;
                     d.drive = ~q.shift[0];  // see RULE19
                  end
               end else begin
                  d.timer = q.timer + 1'b1;
                  if (q.timer == TMR_W'(RDV_CYC - 1)) begin
                     d.drive  = 1'b0;  // see RULE19
                     d.slot   = 1'b0;
                     d.shift  = {1'b0, q.shift[7:1]};  // see RULE25
                     d.bitcnt = q.bitcnt + 1'b1;
                     if (q.bitcnt == 3'h7) d.state = S_IDLE;  // see RULE23
                  end
               end
            end
            S_PUSH: begin
               if (f_in_ready) d.state = S_IDLE;
            end
         endcase
      end

      // first cycle after reset: fetch stored values, pick the mode
      if (!q.loaded) begin
         d.loaded = 1'b1;
         d.high   = nv_high;
         d.low    = nv_low;
         d.status = nv_status;
         d.thermo = nv_status[ST_TR];  // see RULE1
      end

      d.run_out = d.thermo | d.run;
      // open drain only; thermostat output released while supply is low
      d.oe_n = ~(d.drive | (d.thermo & q.vdd_s & (thermo_active ^ d.status[ST_POL])));  // see RULE12
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q        <= '0;
         q.dq_m   <= 1'b1;
         q.dq_s   <= 1'b1;
         q.dq_p   <= 1'b1;
         q.oe_n   <= 1'b1;
         q.state  <= S_IDLE;
         q.high   <= HIGH_RST;
         q.low    <= LOW_RST;
         q.status <= STATUS_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign dq_out          = 1'b0;
   assign dq_oe_n         = q.oe_n;
   assign nv_wr           = q.wr;
   assign nv_sel          = q.sel;
   assign nv_data         = q.wdata;
   assign high_trip_limit = q.high;
   assign low_trip_limit  = q.low;
   assign status_reg      = q.status;
   assign conv_start      = q.start;
   assign conv_stop       = q.stop;
   assign conv_run        = q.run_out;
   assign thermo_mode     = q.thermo;

endmodule : stw_slave

`default_nettype wire

//--- testbench/stw_slave_monitor.sv
/* stw_slave_monitor: pin-level assertions for the thermostat slave port.
   assumes a bind onto stw_slave and the single ref_clk domain. */
`timescale 1ns/1ps
`default_nettype none

module stw_slave_monitor
   import stw_pkg::*;
#(
   parameter int RST_CYC = 200,
   parameter int PDH_CYC = 20,
   parameter int PDL_CYC = 40,
   parameter int RDV_CYC = 15
) (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       dq_in,
   input wire logic       dq_out,
   input wire logic       dq_oe_n,
   input wire logic       vdd_in,
   input wire logic       thermo_active,
   input wire logic       nv_wr,
   input wire logic [1:0] nv_sel,
   input wire logic [7:0] nv_data,
   input wire logic [7:0] high_trip_limit,
   input wire logic [7:0] low_trip_limit,
   input wire logic [7:0] status_reg,
   input wire logic       conv_start,
   input wire logic       conv_run,
   input wire logic       thermo_mode
);
   localparam int P_LO = PDH_CYC + 2;
   localparam int P_HI = PDH_CYC + 8;
   logic [15:0] low_q;
   logic [15:0] oe_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         low_q <= 16'h0000;
         oe_q  <= 16'h0000;
      end else begin
         low_q <= dq_in ? 16'h0000 : ((&low_q) ? low_q : low_q + 16'h0001);
         oe_q  <= dq_oe_n ? 16'h0000 : oe_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_reset_end;
      $rose(dq_in) && (low_q >= RST_CYC) && vdd_in && !thermo_mode;
   endsequence
   sequence s_presence;
      ##[P_LO:P_HI] $fell(dq_oe_n);
   endsequence

   a_pin_never_high: assert property (dq_out == 1'b0)
      else $error("pin driven high");
   a_presence_start: assert property (s_reset_end |-> s_presence)
      else $error("presence not in window");
   a_drive_len: assert property ($rose(dq_oe_n) && !thermo_mode && vdd_in
      |-> (oe_q == PDL_CYC) || (oe_q == RDV_CYC)) else $error("low drive length wrong");
   a_thermo_silent: assert property (thermo_mode && $past(thermo_mode) && !$past(thermo_active)
      && !thermo_active && !status_reg[ST_POL] |-> dq_oe_n) else $error("pin pulled in thermostat mode");
   a_run_on_start: assert property (conv_start |-> ##[0:1] conv_run)
      else $error("run not set by start");
   a_wr_high: assert property (nv_wr && nv_sel == TGT_HIGH |-> high_trip_limit == nv_data)
      else $error("high limit not updated");
   a_wr_low: assert property (nv_wr && nv_sel == TGT_LOW |-> low_trip_limit == nv_data)
      else $error("low limit not updated");
   a_mode_keeps_bit: assert property ($changed(thermo_mode) && !$past(rst)
      |-> $stable(status_reg[ST_TR])) else $error("mode bit altered by toggle");
   a_toggle_vdd: assert property ($changed(thermo_mode) && !$past(rst) |-> !$past(vdd_in, 6))
      else $error("mode changed with supply up");
endmodule : stw_slave_monitor

bind stw_slave stw_slave_monitor #(.RST_CYC(RST_CYC), .PDH_CYC(PDH_CYC), .PDL_CYC(PDL_CYC), .RDV_CYC(RDV_CYC))
   u_mon (.ref_clk, .rst, .dq_in, .dq_out, .dq_oe_n, .vdd_in, .thermo_active, .nv_wr, .nv_sel, .nv_data,
          .high_trip_limit, .low_trip_limit, .status_reg, .conv_start, .conv_run, .thermo_mode);

`default_nettype wire

//--- testbench/stw_master_model.sv
/* stw_master_model: single bus master pulling the shared data line.
   assumes a pull-up wire built by the bench and tasks started at a falling edge. */
`timescale 1ns/1ps
`default_nettype none

module stw_master_model (
   input  wire logic ref_clk,
   input  wire logic dq_line,
   output logic      m_pull
);
   initial m_pull = 1'b0;

   // master originates every signal but presence
   task automatic hold(input int n, input logic low);
      m_pull = low;
      repeat (n) @(negedge ref_clk);
   endtask : hold

   task automatic reset_pulse(output logic seen);
      hold(250, 1'b1);
      seen = 1'b0;
      m_pull = 1'b0;
      repeat (200) begin
         @(negedge ref_clk);
         if (!dq_line) seen = 1'b1;
      end
   endtask : reset_pulse

   task automatic write_bit(input logic b);
      hold(b ? 2 : 60, 1'b1);
      hold(b ? 60 : 2, 1'b0);
   endtask : write_bit

   task automatic read_bit(output logic b);
      hold(2, 1'b1);
      hold(10, 1'b0);
      b = dq_line;
      repeat (50) @(negedge ref_clk);
   endtask : read_bit

   task automatic write_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) write_bit(v[i]);
   endtask : write_byte

   task automatic read_byte(output logic [7:0] v);
      logic b;
      for (int i = 0; i < 8; i++) begin
         read_bit(b);
         v[i] = b;
      end
   endtask : read_byte

   task automatic pulses(input int n);
      repeat (n) begin
         hold(15, 1'b1);
         hold(15, 1'b0);
      end
   endtask : pulses
endmodule : stw_master_model

`default_nettype wire

//--- testbench/tb.sv
/* tb: self-checking bench for stw_slave against a queue-based model.
   assumes stw_master_model drives the line and the monitor is bound. */
`timescale 1ns/1ps
`default_nettype none

module tb
   import stw_pkg::*;
;
   logic       ref_clk, rst, vdd_in, nv_ready, nv_wr, conv_start, conv_stop, conv_run, thermo_mode;
   logic       m_pull, dq_oe_n, dq_out, seen, conv_done, thf_set, tlf_set, thermo_active;
   logic [1:0] nv_sel;
   logic [7:0] nv_high, nv_low, nv_status, temp_value, nv_data, high_trip_limit, low_trip_limit;
   logic [7:0] status_reg, r_hi, r_lo;
   logic [9:0] wq[$];
   wire logic  dq_line;
   int         err_total = 0;
   int         tests_run = 0;
   int         n_start = 0;
   int         n_stop = 0;

   assign dq_line = ~(m_pull | ~dq_oe_n);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   stw_master_model bfm (.ref_clk(ref_clk), .dq_line(dq_line), .m_pull(m_pull));
   stw_slave #(.RST_CYC(200), .PDH_CYC(20), .PDL_CYC(40), .SAMPLE_CYC(30), .RDV_CYC(15), .PDN_LIMIT(100)) DUT (
      .ref_clk(ref_clk), .rst(rst), .dq_in(dq_line), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .vdd_in(vdd_in),
      .nv_high(nv_high), .nv_low(nv_low), .nv_status(nv_status), .temp_value(temp_value), .conv_done(conv_done),
      .thf_set(thf_set), .tlf_set(tlf_set), .thermo_active(thermo_active), .nv_ready(nv_ready), .nv_wr(nv_wr),
      .nv_sel(nv_sel), .nv_data(nv_data), .high_trip_limit(high_trip_limit), .low_trip_limit(low_trip_limit),
      .status_reg(status_reg), .conv_start(conv_start), .conv_stop(conv_stop), .conv_run(conv_run),
      .thermo_mode(thermo_mode));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic xact(input logic [7:0] cmd, input logic [7:0] dat, input int kind);
      logic [7:0] v;
      bfm.reset_pulse(seen);
      check(10'(seen), 10'h001);
      bfm.write_byte(cmd);
      if (kind == 1) begin
         wq.push_back({(cmd == 8'h01) ? TGT_HIGH : (cmd == 8'h02) ? TGT_LOW : TGT_STATUS, dat});
         bfm.write_byte(dat);
      end else if (kind == 2) begin
         bfm.read_byte(v);
         check(10'(v), 10'(dat));
      end
   endtask : xact

   task automatic toggle(input int n);
      vdd_in = 1'b0;
      repeat (5) @(negedge ref_clk);
      bfm.pulses(n);
      repeat (5) @(negedge ref_clk);
      vdd_in = 1'b1;
      repeat (10) @(negedge ref_clk);
   endtask : toggle

   always @(posedge ref_clk) begin
      if (nv_wr === 1'b1) begin
         if (wq.size() == 0)
            check(10'h000, 10'h3FF);
         else
            check({nv_sel, nv_data}, wq.pop_front());
      end
      n_start += int'(conv_start === 1'b1);
      n_stop += int'(conv_stop === 1'b1);
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      err_total++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'hA848));
      rst = 1'b1;
      vdd_in = 1'b1;
      nv_ready = 1'b0;
      {conv_done, thf_set, tlf_set, thermo_active} = {1'($urandom), 3'h0};
      nv_high = $urandom;
      nv_low = $urandom;
      nv_status = 8'($urandom) & 8'hFB;
      temp_value = $urandom;
      r_hi = $urandom;
      r_lo = $urandom;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      repeat (5) @(negedge ref_clk);
      check(10'(thermo_mode), 10'(nv_status[ST_TR]));
      xact(8'h01, r_hi, 1);
      xact(8'h02, r_lo, 1);
      xact(8'h0C, 8'h04, 1);
      xact(8'h01, ~r_hi, 1);
      check(10'(wq.size()), 10'h004);
      nv_ready = 1'b1;
      for (int i = 0; i < 50 && wq.size() > 0; i++) @(negedge ref_clk);
      check(10'(wq.size()), 10'h000);
      for (int i = 0; i < 4; i++) bfm.write_bit(1'b1);
      xact(8'hA1, ~r_hi, 2);
      xact(8'hA2, r_lo, 2);
      xact(8'hAC, {conv_done, 7'h44}, 2);
      {thf_set, tlf_set} = 2'h3;
      @(negedge ref_clk) {thf_set, tlf_set} = 2'h0;
      check(10'(status_reg[4:3]), 10'h003);
      xact(8'hAA, temp_value, 2);
      xact(8'hEE, 8'h00, 0);
      check(10'(conv_run), 10'h001);
      xact(8'h22, 8'h00, 0);
      check(10'(n_start), 10'h001);
      check(10'(n_stop), 10'h001);
      toggle(15);
      check(10'(thermo_mode), 10'h000);
      toggle(16);
      check(10'(thermo_mode), 10'h001);
      thermo_active = 1'b1;
      repeat (3) @(negedge ref_clk);
      check(10'(dq_line), 10'h000);
      thermo_active = 1'b0;
      bfm.reset_pulse(seen);
      check(10'(seen), 10'h000);
      toggle(16);
      check(10'(thermo_mode), 10'h000);
      check(10'(status_reg[ST_TR]), 10'h001);
      vdd_in = 1'b0;
      bfm.hold(150, 1'b1);
      bfm.hold(5, 1'b0);
      vdd_in = 1'b1;
      repeat (10) @(negedge ref_clk);
      check(10'(thermo_mode), 10'h001);
      wrap_up();
   end
endmodule : tb

`default_nettype wire
